// [hdl/amcs_pkg.sv]
// Constants for the converter configuration-source selector.
// Assumes a single 100 MHz clock and an AXI4-Lite register port.
`default_nettype none
package amcs_pkg;
    localparam int AMCS_CLK_MHZ = 100;
    localparam logic [7:0] AMCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] AMCS_STAT_OFS = 8'h04;
    localparam int AMCS_SRST_BIT = 0;
    localparam int AMCS_PIN_PRIORITY_OVERRIDE_BIT_BIT = 1;
    localparam int AMCS_LOWLAT_BIT = 2;
    localparam int AMCS_PD_LSB = 4;
    localparam int AMCS_STAT_LOWLAT_BIT = 0;
    localparam int AMCS_STAT_PIN_PRIORITY_OVERRIDE_BIT_BIT = 1;
    localparam int AMCS_STAT_STRAP_BIT = 2;
    localparam int AMCS_STAT_MODE_LSB = 4;
    localparam logic [2:0] AMCS_PD_RST = 3'h0;
    localparam logic AMCS_PIN_PRIORITY_OVERRIDE_BIT_RST = 1'b0;
    localparam logic AMCS_LOWLAT_RST = 1'b0;
    localparam int AMCS_LAT_DEFAULT = 14;
    localparam int AMCS_LAT_LOW = 10;
    localparam logic [1:0] AMCS_RESP_OKAY = 2'b00;
    localparam logic [1:0] AMCS_RESP_SLVERR = 2'b10;
    localparam logic [2:0] AMCS_MODE_NORMAL = 3'b000;
    localparam logic [2:0] AMCS_MODE_A_OFF = 3'b001;
    localparam logic [2:0] AMCS_MODE_B_OFF = 3'b010;
    localparam logic [2:0] AMCS_MODE_AB_OFF = 3'b011;
    localparam logic [2:0] AMCS_MODE_GLOBAL_PD = 3'b100;
    localparam logic [2:0] AMCS_MODE_A_STBY = 3'b101;
    localparam logic [2:0] AMCS_MODE_B_STBY = 3'b110;
    localparam logic [2:0] AMCS_MODE_INTERLEAVED = 3'b111;
endpackage
`default_nettype wire

// [hdl/amcs_top.sv]
// Configuration-source selector of a dual-channel converter.
// Assumes pins synchronous to aclk, AXI4-Lite master on the register port.
// Function
// R1: Reset pin high selects pin-strapped control
// R2: Strapped mode configures from mode pins
// R3: Strapped: frame/shift-clock pins are level inputs
// R4: Strapped: shift-data pin has no function
// R5: Reset pin low enables serial register port
// R6: Controller resets registers before programming
// R7: Controller keeps reset pin low afterwards
// R8: Serial-only: controller grounds mode pins
// R9: Mixed scheme: pins configure, registers accessible
// R10: Override zero: mode pins govern power-down
// R11: Override one: register bits govern power-down
// R12: Low-latency mode gives 10-cycle latency
// R13: Interleaved: A on falling, B rising
// R14: Three-bit mode pin code selects mode
// R15: Soft reset restores defaults, self-clears
// R16: Default latency is 14 sample cycles
`default_nettype none
module amcs_top #(
    parameter int SAMPLE_DIV = 4,
    parameter int DATA_W = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reset_pin,
    input wire logic frame_select_pin,
    input wire logic shift_clk_pin,
    input wire logic shift_data_pin,
    input wire logic [1:0] frame_select_level,
    input wire logic [1:0] shift_clk_level,
    input wire logic mode_pin_1,
    input wire logic mode_pin_2,
    input wire logic mode_pin_3,
    input wire logic [DATA_W-1:0] ch_a_in,
    input wire logic [DATA_W-1:0] ch_b_in,
    output logic strap_mode,
    output logic serial_port_en,
    output logic [2:0] serial_pins,
    output logic [1:0] format_level,
    output logic [1:0] gain_level,
    output logic [2:0] eff_mode,
    output logic global_pd,
    output logic stby_a,
    output logic stby_b,
    output logic oe_a,
    output logic oe_b,
    output logic [DATA_W-1:0] out_a,
    output logic [DATA_W-1:0] out_b
);
    localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(SAMPLE_DIV / 2);
    localparam int DEPTH = amcs_pkg::AMCS_LAT_DEFAULT;

    // Sample clock divider: rising edge enable and falling edge enable
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic sample_en, half_en;
    always_comb
    begin
        nxt_div = (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1;
        sample_en = (div_ff == '0);
        half_en = (div_ff == DIV_HALF);
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end

    // AXI4-Lite write and read channels
    logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
    logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic awready_ff, wready_ff, arready_ff;
    logic wr_fire;
    logic pin_priority_override_bit_ff, lowlat_ff, srst_ff, nxt_pin_priority_override_bit, nxt_lowlat, nxt_srst;
    logic [2:0] pd_reg_ff, nxt_pd_reg;
    logic [2:0] eff_mode_ff, nxt_eff_mode;
    logic strap_ff;
    always_comb
    begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && awready_ff)
        begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff)
        begin
            nxt_w_hold = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
        if (wr_fire)
        begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (awaddr_ff == amcs_pkg::AMCS_CTRL_OFS ||
                         awaddr_ff == amcs_pkg::AMCS_STAT_OFS) ?
                        amcs_pkg::AMCS_RESP_OKAY : amcs_pkg::AMCS_RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
            nxt_bvalid = 1'b0;
        if (s_axi_arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = amcs_pkg::AMCS_RESP_OKAY;
            nxt_rdata = '0;
            case (s_axi_araddr)
                amcs_pkg::AMCS_CTRL_OFS:
                begin
                    nxt_rdata[amcs_pkg::AMCS_PIN_PRIORITY_OVERRIDE_BIT_BIT] = pin_priority_override_bit_ff;
                    nxt_rdata[amcs_pkg::AMCS_LOWLAT_BIT] = lowlat_ff;
                    nxt_rdata[amcs_pkg::AMCS_PD_LSB +: 3] = pd_reg_ff;
                end
                amcs_pkg::AMCS_STAT_OFS:
                begin
                    nxt_rdata[amcs_pkg::AMCS_STAT_LOWLAT_BIT] = lowlat_ff;
                    nxt_rdata[amcs_pkg::AMCS_STAT_PIN_PRIORITY_OVERRIDE_BIT_BIT] = pin_priority_override_bit_ff;
                    nxt_rdata[amcs_pkg::AMCS_STAT_STRAP_BIT] = strap_ff;
                    nxt_rdata[amcs_pkg::AMCS_STAT_MODE_LSB +: 3] = eff_mode_ff;
                end
                default:
                    nxt_rresp = amcs_pkg::AMCS_RESP_SLVERR;
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
            nxt_rvalid = 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= amcs_pkg::AMCS_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= amcs_pkg::AMCS_RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
        end
        else
        begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            // Ready drops while a word is held, so one write at a time
            awready_ff <= !nxt_aw_hold && !nxt_bvalid;
            wready_ff <= !nxt_w_hold && !nxt_bvalid;
            arready_ff <= !nxt_rvalid;
        end
    end

    // Control register; a strapped device or a reset pulse holds defaults
    logic ctrl_wr;
    always_comb
    begin
        ctrl_wr = wr_fire && wstrb_ff[0] &&
                  awaddr_ff == amcs_pkg::AMCS_CTRL_OFS;
        nxt_pin_priority_override_bit = pin_priority_override_bit_ff;
        nxt_lowlat = lowlat_ff;
        nxt_pd_reg = pd_reg_ff;
        nxt_srst = 1'b0;
        // R15: self-clearing soft reset
        if (ctrl_wr && wdata_ff[amcs_pkg::AMCS_SRST_BIT])
            nxt_srst = 1'b1;
        else if (ctrl_wr)
        begin
            nxt_pin_priority_override_bit = wdata_ff[amcs_pkg::AMCS_PIN_PRIORITY_OVERRIDE_BIT_BIT];
            nxt_lowlat = wdata_ff[amcs_pkg::AMCS_LOWLAT_BIT];
            nxt_pd_reg = wdata_ff[amcs_pkg::AMCS_PD_LSB +: 3];
        end
        // R6: pin pulse or soft reset restores defaults
        if (reset_pin || srst_ff)
        begin
            nxt_pin_priority_override_bit = amcs_pkg::AMCS_PIN_PRIORITY_OVERRIDE_BIT_RST;
            nxt_lowlat = amcs_pkg::AMCS_LOWLAT_RST;
            nxt_pd_reg = amcs_pkg::AMCS_PD_RST;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_priority_override_bit_ff <= amcs_pkg::AMCS_PIN_PRIORITY_OVERRIDE_BIT_RST;
            lowlat_ff <= amcs_pkg::AMCS_LOWLAT_RST;
            pd_reg_ff <= amcs_pkg::AMCS_PD_RST;
            srst_ff <= 1'b0;
        end
        else
        begin
            pin_priority_override_bit_ff <= nxt_pin_priority_override_bit;
            lowlat_ff <= nxt_lowlat;
            pd_reg_ff <= nxt_pd_reg;
            srst_ff <= nxt_srst;
        end
    end

    // Configuration source selection and mode decode
    logic [2:0] pin_code;
    logic [1:0] nxt_fmt, nxt_gain, fmt_ff, gain_ff;
    logic [2:0] nxt_ser, ser_ff;
    logic ser_en_ff;
    logic gpd_ff, sa_ff, sb_ff, oea_ff, oeb_ff;
    logic nxt_gpd, nxt_sa, nxt_sb, nxt_oea, nxt_oeb;
    always_comb
    begin
        pin_code = {mode_pin_1, mode_pin_2, mode_pin_3};
        // R1: strapped pins govern while reset pin is high
        // R2: strapped mode tracks the mode pins
        // R9: mixed scheme still configures from the pins
        // R10: override clear selects the pin code
        // R11: override set selects the register code
        if (!reset_pin && pin_priority_override_bit_ff)
            nxt_eff_mode = pd_reg_ff;
        else
            nxt_eff_mode = pin_code;
        // R3: level-sensed pins only mean something when strapped
        nxt_fmt = reset_pin ? frame_select_level : fmt_ff;
        nxt_gain = reset_pin ? shift_clk_level : gain_ff;
        // R4: shift-data pin is dropped when strapped
        // R5: serial port follows the pins only with reset pin low
        nxt_ser = reset_pin ? 3'b000 :
                  {frame_select_pin, shift_clk_pin, shift_data_pin};
        // R14: three-bit mode code decode
        nxt_gpd = 1'b0;
        nxt_sa = 1'b0;
        nxt_sb = 1'b0;
        nxt_oea = 1'b1;
        nxt_oeb = 1'b1;
        case (nxt_eff_mode)
            amcs_pkg::AMCS_MODE_NORMAL: ;
            amcs_pkg::AMCS_MODE_A_OFF: nxt_oea = 1'b0;
            amcs_pkg::AMCS_MODE_B_OFF: nxt_oeb = 1'b0;
            amcs_pkg::AMCS_MODE_AB_OFF:
            begin
                nxt_oea = 1'b0;
                nxt_oeb = 1'b0;
            end
            amcs_pkg::AMCS_MODE_GLOBAL_PD:
            begin
                nxt_gpd = 1'b1;
                nxt_oea = 1'b0;
                nxt_oeb = 1'b0;
            end
            amcs_pkg::AMCS_MODE_A_STBY:
            begin
                nxt_sa = 1'b1;
                nxt_oea = 1'b0;
            end
            amcs_pkg::AMCS_MODE_B_STBY:
            begin
                nxt_sb = 1'b1;
                nxt_oeb = 1'b0;
            end
            amcs_pkg::AMCS_MODE_INTERLEAVED: nxt_oeb = 1'b0;
            default: ;
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eff_mode_ff <= amcs_pkg::AMCS_MODE_NORMAL;
            strap_ff <= 1'b0;
            ser_en_ff <= 1'b0;
            fmt_ff <= '0;
            gain_ff <= '0;
            ser_ff <= '0;
            gpd_ff <= 1'b0;
            sa_ff <= 1'b0;
            sb_ff <= 1'b0;
            oea_ff <= 1'b0;
            oeb_ff <= 1'b0;
        end
        else
        begin
            eff_mode_ff <= nxt_eff_mode;
            strap_ff <= reset_pin;
            ser_en_ff <= !reset_pin;
            fmt_ff <= nxt_fmt;
            gain_ff <= nxt_gain;
            ser_ff <= nxt_ser;
            gpd_ff <= nxt_gpd;
            sa_ff <= nxt_sa;
            sb_ff <= nxt_sb;
            oea_ff <= nxt_oea;
            oeb_ff <= nxt_oeb;
        end
    end

    // Sample pipeline: one stage per sample clock
    logic [2*DATA_W-1:0] pipe_ff [DEPTH];
    logic [2*DATA_W-1:0] nxt_pipe [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_pipe
            always_comb
            begin
                if (!sample_en)
                    nxt_pipe[g] = pipe_ff[g];
                else if (g == 0)
                    nxt_pipe[g] = {ch_a_in, ch_b_in};
                else
                    nxt_pipe[g] = pipe_ff[(g == 0) ? 0 : g - 1];
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pipe_ff[g] <= '0;
                else
                    pipe_ff[g] <= nxt_pipe[g];
            end
        end
    endgenerate

    // Output stage; shared pins carry B on rising and A on falling
    logic [2*DATA_W-1:0] tap;
    logic [DATA_W-1:0] outa_ff, outb_ff, ahold_ff;
    logic [DATA_W-1:0] nxt_outa, nxt_outb, nxt_ahold;
    logic ilv;
    always_comb
    begin
        // R12: low-latency tap
        // R16: default tap
        tap = lowlat_ff ? pipe_ff[amcs_pkg::AMCS_LAT_LOW - 1] :
                          pipe_ff[amcs_pkg::AMCS_LAT_DEFAULT - 1];
        ilv = (eff_mode_ff == amcs_pkg::AMCS_MODE_INTERLEAVED);
        nxt_outa = outa_ff;
        nxt_outb = outb_ff;
        nxt_ahold = ahold_ff;
        // R13: B launched on rising, A on falling
        if (sample_en)
        begin
            nxt_ahold = tap[2*DATA_W-1:DATA_W];
            nxt_outa = ilv ? tap[DATA_W-1:0] : tap[2*DATA_W-1:DATA_W];
            nxt_outb = ilv ? '0 : tap[DATA_W-1:0];
        end
        else if (half_en && ilv)
            nxt_outa = ahold_ff;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            outa_ff <= '0;
            outb_ff <= '0;
            ahold_ff <= '0;
        end
        else
        begin
            outa_ff <= nxt_outa;
            outb_ff <= nxt_outb;
            ahold_ff <= nxt_ahold;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign strap_mode = strap_ff;
    assign serial_port_en = ser_en_ff;
    assign serial_pins = ser_ff;
    assign format_level = fmt_ff;
    assign gain_level = gain_ff;
    assign eff_mode = eff_mode_ff;
    assign global_pd = gpd_ff;
    assign stby_a = sa_ff;
    assign stby_b = sb_ff;
    assign oe_a = oea_ff;
    assign oe_b = oeb_ff;
    assign out_a = outa_ff;
    assign out_b = outb_ff;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    strap_pins_a: assert property (reset_pin |=> // R1
        eff_mode_ff == $past(pin_code)) else $error("strap mode lost");
    strap_level_a: assert property (reset_pin |=> // R3
        fmt_ff == $past(frame_select_level) &&
        gain_ff == $past(shift_clk_level)) else $error("level pins");
    strap_shift_data_pin_a: assert property (reset_pin |=> // R4
        ser_ff == 3'b000) else $error("serial pins not idle");
    serial_en_a: assert property (!reset_pin |=> // R5
        serial_port_en && !strap_mode) else $error("serial port off");
    pin_priority_override_bit_zero_a: assert property (!reset_pin && !pin_priority_override_bit_ff |=> // R10
        eff_mode_ff == $past(pin_code)) else $error("pins ignored");
    pin_priority_override_bit_one_a: assert property (!reset_pin && pin_priority_override_bit_ff |=> // R11
        eff_mode_ff == $past(pd_reg_ff)) else $error("override lost");
    soft_reset_a: assert property (ctrl_wr && // R15
        wdata_ff[amcs_pkg::AMCS_SRST_BIT] |=> srst_ff ##1 (!srst_ff &&
        !pin_priority_override_bit_ff && !lowlat_ff && pd_reg_ff == amcs_pkg::AMCS_PD_RST))
        else $error("soft reset failed");
    lat_tap_a: assert property (sample_en && !ilv |=> // R12
        out_a == $past(lowlat_ff ?
        pipe_ff[amcs_pkg::AMCS_LAT_LOW - 1][2*DATA_W-1:DATA_W] :
        pipe_ff[amcs_pkg::AMCS_LAT_DEFAULT - 1][2*DATA_W-1:DATA_W]))
        else $error("latency tap");
    mux_fall_a: assert property (half_en && ilv && !sample_en |=> // R13
        out_a == $past(ahold_ff)) else $error("falling A");
    // Mode and enables load from one next value, so leaving a mode is safe
    mux_oeb_a: assert property (ilv |-> !oe_b) // R13
        else $error("shared pins B enabled");
    mode_dec_a: assert property ($past(nxt_eff_mode) == // R14
        amcs_pkg::AMCS_MODE_GLOBAL_PD |-> global_pd && !oe_a && !oe_b)
        else $error("power down decode");
endmodule
`default_nettype wire

// [sim/adc_mode_config_select_test.sv]
// Self-checking bench for the configuration-source selector.
// Assumes amcs_top, amcs_pkg and the controller model; AXI4-Lite master.
`default_nettype none
module adc_mode_config_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam int DW = 11;
    localparam logic [7:0] CTRL = amcs_pkg::AMCS_CTRL_OFS;
    localparam logic [7:0] STAT = amcs_pkg::AMCS_STAT_OFS;
    // Decoded {global_pd, stby_a, stby_b, oe_a, oe_b} per mode code
    localparam logic [39:0] DEC = 40'h11_9300_0823;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, scheme;
    logic reset_pin, frame_select_pin, shift_clk_pin, shift_data_pin;
    logic [1:0] frame_select_level, shift_clk_level, format_level, gain_level;
    logic mode_pin_1, mode_pin_2, mode_pin_3, strap_mode, serial_port_en;
    logic [2:0] serial_pins, eff_mode, code, pins;
    logic global_pd, stby_a, stby_b, oe_a, oe_b;
    logic [DW-1:0] ch_a_in, ch_b_in, out_a, out_b;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int i;

    amcs_top #(.SAMPLE_DIV(DIV), .DATA_W(DW)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .reset_pin, .frame_select_pin,
        .shift_clk_pin, .shift_data_pin, .frame_select_level,
        .shift_clk_level, .mode_pin_1, .mode_pin_2, .mode_pin_3, .ch_a_in,
        .ch_b_in, .strap_mode, .serial_port_en, .serial_pins, .format_level,
        .gain_level, .eff_mode, .global_pd, .stby_a, .stby_b, .oe_a, .oe_b,
        .out_a, .out_b
    );
    amcs_ctrl_model #(.DATA_W(DW)) ctrl_u (
        .aclk, .scheme, .code, .reset_pin, .frame_select_pin, .shift_clk_pin,
        .shift_data_pin, .frame_select_level, .shift_clk_level, .mode_pin_1,
        .mode_pin_2, .mode_pin_3, .ch_a_in, .ch_b_in
    );

    always #5 aclk = ~aclk;

    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard: the tests need well under a tenth of this
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Handshakes are judged on values settled before the edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic ha, hw, hb;
        hb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hb)
        begin
            #1;
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha)
                s_axi_awvalid <= 1'b0;
            if (hw)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ha, hr;
        hr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hr)
        begin
            #1;
            ha = s_axi_arvalid && s_axi_arready;
            hr = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ha)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic mode_chk(input logic [2:0] c, input logic [2:0] e);
        code <= c;
        tick(3);
        #1;
        check("eff_mode", eff_mode, e);
        check("decode", {global_pd, stby_a, stby_b, oe_a, oe_b},
            DEC[e*5 +: 5]);
        @(posedge aclk);
    endtask

    // Output lags the input counter by lat ticks plus up to 3 cycles
    task automatic lat_chk(input int lat);
        logic [DW-1:0] prev, d;
        int hits;
        hits = 0;
        tick(20 * DIV);
        #1;
        prev = out_a;
        repeat (12)
        begin
            @(posedge aclk);
            #1;
            d = ch_a_in - out_a;
            if (out_a !== prev)
            begin
                hits++;
                check("latency", d >= lat * DIV && d <= lat * DIV + 3,
                    1'b1);
                check("out_b", out_b, {~out_a[DW-1], out_a[DW-2:0]});
            end
            prev = out_a;
        end
        check("sample steps", hits >= 2, 1'b1);
        @(posedge aclk);
    endtask

    task automatic mux_chk();
        logic [DW-1:0] da, db;
        int ha, hb;
        ha = 0;
        hb = 0;
        code <= 3'h7;
        tick(20 * DIV);
        repeat (4 * DIV)
        begin
            #1;
            check("out_b idle", out_b, 0);
            check("oe_b", oe_b, 1'b0);
            da = ch_a_in - out_a;
            db = ch_b_in - out_a;
            if (da < 100)
                ha++;
            if (db < 100)
                hb++;
            @(posedge aclk);
        end
        check("mux a seen", ha > 0, 1'b1);
        check("mux b seen", hb > 0, 1'b1);
    endtask

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        scheme = 2'h0;
        code = 3'h0;
        tick(16);
        aresetn <= 1'b1;
        tick(2);
        #1;
        check("strap_mode", strap_mode, 1'b1);
        check("serial_port_en", serial_port_en, 1'b0);
        check("serial_pins", serial_pins, 3'h0);
        @(posedge aclk);
        for (i = 0; i < 8; i++)
        begin
            mode_chk(i[2:0], i[2:0]);
            check("format_level", format_level, i[1:0]);
            check("gain_level", gain_level, i[2:1]);
        end
        code <= 3'h0;
        lat_chk(14);
        // Register writes must not stick while strapped
        axi_write(CTRL, 32'h0000_0046, rsp);
        axi_read(STAT, rd, rsp);
        check("strap status", rd, 32'h0000_0004);
        scheme <= 2'h2;
        code <= 3'h5;
        tick(8);
        #1;
        check("serial_port_en", serial_port_en, 1'b1);
        check("strap_mode", strap_mode, 1'b0);
        repeat (6)
        begin
            pins = {frame_select_pin, shift_clk_pin, shift_data_pin};
            @(posedge aclk);
            #1;
            check("serial_pins", serial_pins, pins);
        end
        @(posedge aclk);
        mode_chk(3'h5, 3'h5);
        axi_write(CTRL, 32'h0000_0042, rsp);
        check("ctrl resp", rsp, amcs_pkg::AMCS_RESP_OKAY);
        mode_chk(3'h5, 3'h4);
        axi_read(STAT, rd, rsp);
        check("status pin_priority_override_bit", rd, 32'h0000_0042);
        axi_write(CTRL, 32'h0000_0003, rsp);
        tick(3);
        axi_read(CTRL, rd, rsp);
        check("ctrl after srst", rd, 32'h0000_0000);
        mode_chk(3'h6, 3'h6);
        axi_write(CTRL, 32'h0000_0004, rsp);
        axi_read(STAT, rd, rsp);
        check("status lowlat", rd, 32'h0000_0061);
        lat_chk(10);
        mux_chk();
        axi_read(8'h08, rd, rsp);
        check("unmapped rd", rsp, amcs_pkg::AMCS_RESP_SLVERR);
        axi_write(8'h0c, 32'h0000_0042, rsp);
        check("unmapped wr", rsp, amcs_pkg::AMCS_RESP_SLVERR);
        scheme <= 2'h1;
        tick(8);
        mode_chk(3'h7, 3'h0);
        axi_read(STAT, rd, rsp);
        check("serial-only status", rd, 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire

// [sim/amcs_ctrl_model.sv]
// Behavioural model of the external controller on the configuration pins.
// Assumes bench commands change just after a rising aclk edge.
`default_nettype none
module amcs_ctrl_model #(
    parameter int DATA_W = 11
) (
    input wire logic aclk,
    input wire logic [1:0] scheme,
    input wire logic [2:0] code,
    output logic reset_pin,
    output logic frame_select_pin,
    output logic shift_clk_pin,
    output logic shift_data_pin,
    output logic [1:0] frame_select_level,
    output logic [1:0] shift_clk_level,
    output logic mode_pin_1,
    output logic mode_pin_2,
    output logic mode_pin_3,
    output logic [DATA_W-1:0] ch_a_in,
    output logic [DATA_W-1:0] ch_b_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] cnt_ff;
    logic [1:0] scheme_ff;
    logic [1:0] pulse_ff;
    initial
    begin
        cnt_ff = '0;
        scheme_ff = 2'h0;
        pulse_ff = 2'h0;
    end
    always @(posedge aclk)
    begin
        cnt_ff <= cnt_ff + 1'b1;
        scheme_ff <= scheme;
        if (scheme != scheme_ff && scheme != 2'h0)
            pulse_ff <= 2'h3;
        else if (pulse_ff != 2'h0)
            pulse_ff <= pulse_ff - 2'h1;
    end
    assign reset_pin = (scheme == 2'h0) || (pulse_ff != 2'h0);
    assign {mode_pin_1, mode_pin_2, mode_pin_3} =
        (scheme == 2'h1) ? 3'h0 : code;
    assign shift_data_pin = (scheme != 2'h0) && cnt_ff[1];
    // Toggling pins expose a design that listens to them when strapped
    assign frame_select_pin = cnt_ff[3];
    assign shift_clk_pin = cnt_ff[0];
    assign frame_select_level = code[1:0];
    assign shift_clk_level = code[2:1];
    // Samples change every cycle; B differs from A in its top bit
    assign ch_a_in = cnt_ff;
    assign ch_b_in = {~cnt_ff[DATA_W-1], cnt_ff[DATA_W-2:0]};
endmodule
`default_nettype wire
